// File: rtl/bbd_pkg.sv
package bbd_pkg;

    // widths
    localparam int PC_W = 21;
    localparam int MA_W = 12;

    // conditional branch opcodes, upper byte
    localparam logic [7:0] OPC_NEG = 8'hE6;
    localparam logic [7:0] OPC_NO_CARRY = 8'hE3;
    localparam logic [7:0] OPC_NOT_NEG = 8'hE7;
    localparam logic [7:0] OPC_NO_OVF = 8'hE5;
    localparam logic [7:0] OPC_NONZERO = 8'hE1;
    // unconditional branch, top five bits
    localparam logic [4:0] OPC_ALWAYS = 5'h1A;
    // bit set, top nibble
    localparam logic [3:0] OPC_SETBIT = 4'h8;

    // instruction field positions
    localparam int FLD_REG_LSB = 0;
    localparam int FLD_ACC_BIT = 8;
    localparam int FLD_BIT_LSB = 9;
    localparam int COND_OFF_W = 8;
    localparam int LONG_OFF_W = 11;

    // access bank split and indexed window
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BANK = 8'h04;
    localparam logic [7:0] REG_IDX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;

    // field positions and reset values
    localparam int CTRL_EXT_BIT = 0;
    localparam int BANK_W = 4;
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_NOP_BIT = 2;
    localparam int STAT_TAKEN_BIT = 3;
    localparam int STAT_CNT_LSB = 8;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [11:0] IDX_RST = 12'h000;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbd_phase_t;
    typedef enum logic [1:0] {OP_NONE, OP_COND, OP_ALWAYS, OP_SETBIT}
        bbd_op_t;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } bbd_flags_t;

    typedef struct packed {
        bbd_op_t op;
        logic taken;
    } bbd_dec_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bbd_memreq_t;

endpackage

// File: rtl/bbd_decode.sv
`timescale 1ns/10ps
`default_nettype none
module bbd_decode import bbd_pkg::*; (
    // instruction and flags
    input wire logic [15:0] instr,
    input wire bbd_flags_t flg,
    // decode result
    output bbd_dec_t dec
);
    wire [7:0] hi = instr[15:8];
    wire is_neg = (hi == OPC_NEG); // RQ1
    wire is_nc = (hi == OPC_NO_CARRY); // RQ5
    wire is_nn = (hi == OPC_NOT_NEG); // RQ6
    wire is_nov = (hi == OPC_NO_OVF); // RQ7
    wire is_nz = (hi == OPC_NONZERO); // RQ8
    wire is_cond = is_neg | is_nc | is_nn | is_nov | is_nz;
    wire is_always = (instr[15:11] == OPC_ALWAYS); // RQ9
    wire is_set = (instr[15:12] == OPC_SETBIT); // RQ11
    wire cond_hit = (is_neg & flg.neg) // RQ1
        | (is_nc & ~flg.carry) // RQ5
        | (is_nn & ~flg.neg) // RQ6
        | (is_nov & ~flg.ovf) // RQ7
        | (is_nz & ~flg.zero); // RQ8
    wire bbd_op_t op_w = is_cond ? OP_COND :
        is_always ? OP_ALWAYS :
        is_set ? OP_SETBIT : OP_NONE;
    wire tk_w = cond_hit | is_always;
    assign dec = {op_w, tk_w};
endmodule
`default_nettype wire

// File: rtl/bbd_ahb_regs.sv
`timescale 1ns/10ps
`default_nettype none
module bbd_ahb_regs import bbd_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // block side
    input wire logic [31:0] stat_word,
    output logic ext_en,
    output logic [3:0] bank,
    output logic [11:0] idx_base
);
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic ext_r, ext_nxt;
    logic [3:0] bank_r, bank_nxt;
    logic [11:0] idx_r, idx_nxt;
    logic [31:0] hrdata_r;
    logic ready_r;
    logic resp_r;

    // only whole-word single transfers are expected; size is not checked
    wire addr_ok = hsel & htrans[1] & hready;
    wire [7:0] ra = haddr[7:0];
    wire do_wr = wr_pend_r;
    wire wr_ctrl = do_wr & (wr_addr_r == REG_CTRL);
    wire wr_bank = do_wr & (wr_addr_r == REG_BANK);
    wire wr_idx = do_wr & (wr_addr_r == REG_IDX);

    assign ext_nxt = wr_ctrl ? hwdata[CTRL_EXT_BIT] : ext_r;
    assign bank_nxt = wr_bank ? hwdata[BANK_W-1:0] : bank_r;
    assign idx_nxt = wr_idx ? hwdata[MA_W-1:0] : idx_r;

    // read sees a write that completes in the same cycle
    wire [31:0] rd_mux =
        (ra == REG_CTRL) ? {31'h0, ext_nxt} :
        (ra == REG_BANK) ? {28'h0, bank_nxt} :
        (ra == REG_IDX) ? {20'h0, idx_nxt} :
        (ra == REG_STAT) ? stat_word : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            ext_r <= CTRL_RST;
            bank_r <= BANK_RST;
            idx_r <= IDX_RST;
            hrdata_r <= 32'h0;
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_r <= ra;
            end
            if (addr_ok & ~hwrite) begin
                hrdata_r <= rd_mux;
            end
            ext_r <= ext_nxt;
            bank_r <= bank_nxt;
            idx_r <= idx_nxt;
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = ready_r;
    assign hresp = resp_r;
    assign ext_en = ext_r;
    assign bank = bank_r;
    assign idx_base = idx_r;
endmodule
`default_nettype wire

// File: rtl/bbd_exec.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1: opcode E6 branches when negative set
// RQ2: signed offset, target incremented pc plus 2n
// RQ3: one cycle untaken, two cycles taken
// RQ4: decode, read, process, write pc Q4
// RQ5: opcode E3 branches when carry clear
// RQ6: opcode E7 branches when negative clear
// RQ7: opcode E5 branches when overflow clear
// RQ8: opcode E1 branches when zero clear
// RQ9: 11010 prefix is unconditional 11-bit branch
// RQ10: unconditional branch always two cycles
// RQ11: top nibble 8 sets one bit
// RQ12: access bit picks access or banked address
// RQ13: extended mode low registers use indexed offset
// RQ14: taken branch flushes prefetch, refetches target
module bbd_exec import bbd_pkg::*; #(
    parameter int PCW = PC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // instruction fetch
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [PCW-1:0] pc_incr,
    // status flags from the core
    input wire bbd_flags_t flags,
    // program counter
    output logic pc_load,
    output logic [PCW-1:0] pc_target,
    output logic fetch_flush,
    // data memory
    input wire logic [7:0] mem_rdata,
    output bbd_memreq_t mem_req,
    // phase and ownership
    output bbd_phase_t q_phase,
    output logic slice_active
);
    // reset release
    logic rst_s1_r, rst_s2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rst_n = rst_s2_r;

    // register file
    logic ext_en;
    logic [3:0] bank;
    logic [11:0] idx_base;
    logic [31:0] stat_word;

    bbd_ahb_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .stat_word(stat_word),
        .ext_en(ext_en),
        .bank(bank),
        .idx_base(idx_base)
    );

    // decode of the presented word
    bbd_dec_t dec_w;
    bbd_decode u_dec (
        .instr(instr_word),
        .flg(flags),
        .dec(dec_w)
    );

    // state
    bbd_phase_t phase_r, phase_nxt;
    bbd_op_t op_r;
    logic taken_r;
    logic [15:0] instr_r;
    logic [PCW-1:0] base_r;
    logic [PCW-1:0] target_r;
    logic nop_r;
    logic pc_load_r;
    logic [PCW-1:0] pc_out_r;
    logic mem_rd_r;
    logic mem_wr_r;
    logic [11:0] mem_addr_r;
    logic [7:0] mem_wdata_r;
    logic last_taken_r;
    logic [7:0] taken_cnt_r;
    logic active_r;

    // phase sequencer
    always_comb begin
        case (phase_r)
            PH_Q1: phase_nxt = PH_Q2;
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: phase_nxt = PH_Q1;
            default: phase_nxt = PH_Q1;
        endcase
    end

    wire at_q1 = (phase_r == PH_Q1);
    wire at_q2 = (phase_r == PH_Q2);
    wire at_q3 = (phase_r == PH_Q3);
    wire at_q4 = (phase_r == PH_Q4);

    // the word fetched during a flush cycle is stale and is dropped
    wire accept = at_q1 & instr_valid & ~nop_r; // RQ14
    wire is_branch = (op_r == OP_COND) | (op_r == OP_ALWAYS);
    wire is_set = (op_r == OP_SETBIT);

    // offset literal, sign extended and doubled
    wire [7:0] off_short = instr_r[COND_OFF_W-1:0];
    wire [10:0] off_long = instr_r[LONG_OFF_W-1:0];
    wire [10:0] off_sel = (op_r == OP_ALWAYS) ? off_long : // RQ9
        {{3{off_short[7]}}, off_short}; // RQ2
    wire [PCW-1:0] off_dbl = {{(PCW-12){off_sel[10]}}, off_sel, 1'b0};
    wire [PCW-1:0] target_w = base_r + off_dbl; // RQ2

    // bit set address forming
    wire [7:0] fld = instr_r[FLD_REG_LSB +: 8];
    wire acc_sel = instr_r[FLD_ACC_BIT];
    wire [2:0] bit_idx = instr_r[FLD_BIT_LSB +: 3];
    wire [11:0] acc_addr = (fld < ACC_SPLIT) ?
        {ACC_LO_BANK, fld} : {ACC_HI_BANK, fld};
    wire [11:0] bank_addr = {bank, fld}; // RQ12
    wire [11:0] idx_addr = idx_base + {4'h0, fld}; // RQ13
    wire idx_mode = ~acc_sel & ext_en & (fld <= IDX_LIMIT); // RQ13
    wire [11:0] set_addr = idx_mode ? idx_addr :
        acc_sel ? bank_addr : acc_addr; // RQ12
    wire [7:0] bit_mask = 8'h01 << bit_idx;
    wire [7:0] set_data = mem_rdata | bit_mask; // RQ11

    // flush spans the whole instruction cycle after a taken branch
    wire load_now = at_q3 & is_branch & taken_r; // RQ4
    wire flush_set = at_q4 & is_branch & taken_r; // RQ3
    wire flush_end = at_q4 & nop_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= PH_Q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Q1 decode: latch word, pc and the branch decision
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= OP_NONE;
            taken_r <= 1'b0;
            instr_r <= 16'h0000;
            base_r <= '0;
            active_r <= 1'b0;
        end else if (at_q1) begin
            op_r <= accept ? dec_w.op : OP_NONE;
            taken_r <= accept & dec_w.taken; // RQ3
            instr_r <= instr_word;
            base_r <= pc_incr;
            active_r <= accept & (dec_w.op != OP_NONE);
        end
    end

    // Q2 read literal and process it into the target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_r <= '0;
        end else if (at_q2 & is_branch) begin
            target_r <= target_w; // RQ4
        end
    end

    // Q4 write pc only when taken; untaken Q4 does nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_r <= 1'b0;
            pc_out_r <= '0;
        end else begin
            pc_load_r <= load_now; // RQ4
            if (load_now) begin
                pc_out_r <= target_r; // RQ10
            end
        end
    end

    // inserted no-operation cycle, prefetch discarded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nop_r <= 1'b0;
        end else if (flush_set) begin
            nop_r <= 1'b1; // RQ14
        end else if (flush_end) begin
            nop_r <= 1'b0; // RQ10
        end
    end

    // bit set: read in Q3, write back in Q4, flags untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_r <= 1'b0;
            mem_wr_r <= 1'b0;
            mem_addr_r <= 12'h000;
            mem_wdata_r <= 8'h00;
        end else begin
            mem_rd_r <= at_q2 & is_set; // RQ11
            mem_wr_r <= at_q3 & is_set; // RQ11
            if (at_q2 & is_set) begin
                mem_addr_r <= set_addr; // RQ12
            end
            if (at_q3 & is_set) begin
                mem_wdata_r <= set_data; // RQ11
            end
        end
    end

    // observation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_taken_r <= 1'b0;
            taken_cnt_r <= 8'h00;
        end else if (at_q4 & is_branch) begin
            last_taken_r <= taken_r;
            if (taken_r) begin
                taken_cnt_r <= taken_cnt_r + 8'h01;
            end
        end
    end

    always_comb begin
        stat_word = 32'h0;
        stat_word[STAT_PHASE_LSB +: 2] = phase_r;
        stat_word[STAT_NOP_BIT] = nop_r;
        stat_word[STAT_TAKEN_BIT] = last_taken_r;
        stat_word[STAT_CNT_LSB +: 8] = taken_cnt_r;
    end

    assign pc_load = pc_load_r;
    assign pc_target = pc_out_r;
    assign fetch_flush = nop_r;
    assign mem_req = {mem_rd_r, mem_wr_r, mem_addr_r, mem_wdata_r};
    assign q_phase = phase_r;
    assign slice_active = active_r;
endmodule
`default_nettype wire

// File: testbench/bbd_exec_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bbd_exec_sva import bbd_pkg::*; #(
    parameter int PCW = PC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // fetch side
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [PCW-1:0] pc_incr,
    input wire bbd_flags_t flags,
    // watched outputs
    input wire logic pc_load,
    input wire logic [PCW-1:0] pc_target,
    input wire logic fetch_flush,
    input wire logic [7:0] mem_rdata,
    input wire bbd_memreq_t mem_req,
    input wire bbd_phase_t q_phase
);
    wire logic cap = q_phase == PH_Q1 && instr_valid && !fetch_flush;
    wire logic [7:0] op = instr_word[15:8];
    wire logic alw = instr_word[15:11] == OPC_ALWAYS;
    wire logic take = (op == OPC_NEG && flags.neg) || alw
        || (op == OPC_NO_CARRY && !flags.carry)
        || (op == OPC_NOT_NEG && !flags.neg)
        || (op == OPC_NO_OVF && !flags.ovf)
        || (op == OPC_NONZERO && !flags.zero);
    wire logic signed [11:0] so = alw ? {instr_word[10:0], 1'b0}
        : {{3{instr_word[7]}}, instr_word[7:0], 1'b0};
    logic [PCW-1:0] tgt_r;
    logic [2:0] bit_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tgt_r <= '0;
            bit_r <= '0;
        end else if (cap) begin
            tgt_r <= pc_incr + PCW'(so);
            bit_r <= instr_word[11:9];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_take; cap |-> ##3 (pc_load == $past(take, 3)); endproperty
    a_take: assert property (p_take)
        else $error("branch decision wrong");
    property p_tgt; pc_load |-> pc_target == tgt_r; endproperty
    a_tgt: assert property (p_tgt)
        else $error("branch target wrong");
    property p_q4; pc_load |-> q_phase == PH_Q4; endproperty
    a_q4: assert property (p_q4)
        else $error("pc written outside fourth phase");
    property p_flush; pc_load |=> fetch_flush [*4] ##1 !fetch_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("inserted idle cycle wrong");
    property p_nop; fetch_flush |-> !pc_load && !mem_req.rd && !mem_req.wr;
    endproperty
    a_nop: assert property (p_nop)
        else $error("activity during idle cycle");
    property p_rd; mem_req.rd |-> q_phase == PH_Q3 ##1 mem_req.wr;
    endproperty
    a_rd: assert property (p_rd)
        else $error("bit set read or write misplaced");
    property p_wd; mem_req.wr |-> mem_req.addr == $past(mem_req.addr)
        && mem_req.wdata == ($past(mem_rdata) | (8'h01 << bit_r));
    endproperty
    a_wd: assert property (p_wd)
        else $error("bit set write data wrong");
    property p_set; cap && instr_word[15:12] == OPC_SETBIT
        |-> ##2 mem_req.rd ##1 mem_req.wr; endproperty
    a_set: assert property (p_set)
        else $error("bit set not done in one cycle");
endmodule
`default_nettype wire

// File: testbench/bbd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module bbd_mem_model import bbd_pkg::*; (
    // clock
    input wire logic clk,
    // data memory port
    input wire bbd_memreq_t mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] last_r;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
        last_r = 8'h00;
    end
    // unselected: show the inverse of the last read, never stale data
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_r;
    always @(posedge clk) begin
        if (mem_req.rd) begin
            last_r <= mem[mem_req.addr];
        end
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule
`default_nettype wire

// File: testbench/branch_and_bit_set_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %0h got %0h", nm, e, g); end end
module branch_and_bit_set_decode_tb import bbd_pkg::*; ;
    typedef struct {logic [15:0] w; logic [3:0] f; logic tk;} bbd_brow_t;
    typedef struct {logic ext; logic [3:0] bk; logic [11:0] ix;
        logic [15:0] w; logic [11:0] a;} bbd_srow_t;
    logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic instr_valid, pc_load, fetch_flush, slice_active;
    logic [15:0] instr_word;
    logic [20:0] pc_incr, pc_target;
    bbd_flags_t flags;
    logic [7:0] mem_rdata, eb;
    bbd_memreq_t mem_req;
    bbd_phase_t q_phase;
    int error_cnt = 0, checks = 0, cyc = 0;
    bbd_brow_t br [14];
    bbd_srow_t sr [7];
    assign hready = hreadyout;
    bbd_exec i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word),
        .pc_incr(pc_incr), .flags(flags), .pc_load(pc_load),
        .pc_target(pc_target), .fetch_flush(fetch_flush),
        .mem_rdata(mem_rdata), .mem_req(mem_req), .q_phase(q_phase),
        .slice_active(slice_active));
    bbd_mem_model i_mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        r = hrdata;
    endtask
    // present one word in a Q1 that will not be flushed, return in its Q4
    task automatic issue(input logic [15:0] w, input logic [3:0] f);
        int n;
        n = 0;
        do begin @(posedge clk); n++;
        end while (!(q_phase === PH_Q4 && pc_load !== 1'b1) && n < 20);
        instr_word <= w;
        flags <= f;
        pc_incr <= {5'h01, w};
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (q_phase !== PH_Q4 && n < 8);
    endtask
    function automatic logic [20:0] tgt(input logic [15:0] w);
        logic [20:0] p;
        p = {5'h01, w};
        if (w[15:11] == OPC_ALWAYS) return p + {{9{w[10]}}, w[10:0], 1'b0};
        return p + {{12{w[7]}}, w[7:0], 1'b0};
    endfunction
    initial begin
        br = '{'{16'hE67F, 4'h8, 1'b1}, '{16'hE605, 4'h7, 1'b0},
            '{16'hE380, 4'hE, 1'b1}, '{16'hE310, 4'h1, 1'b0},
            '{16'hE7F0, 4'h7, 1'b1}, '{16'hE701, 4'h8, 1'b0},
            '{16'hE522, 4'hB, 1'b1}, '{16'hE5FF, 4'h4, 1'b0},
            '{16'hE1FE, 4'hD, 1'b1}, '{16'hE133, 4'h2, 1'b0},
            '{16'hD3FF, 4'h0, 1'b1}, '{16'hD400, 4'hF, 1'b1},
            '{16'hE244, 4'h1, 1'b0}, '{16'hDC00, 4'h0, 1'b0}};
        sr = '{'{1'b0, 4'h0, 12'h000, 16'h8010, 12'h010},
            '{1'b0, 4'h0, 12'h000, 16'h8E80, 12'hF80},
            '{1'b0, 4'h5, 12'h000, 16'h8722, 12'h522},
            '{1'b1, 4'h5, 12'h300, 16'h8A20, 12'h320},
            '{1'b1, 4'h5, 12'h300, 16'h825F, 12'h35F},
            '{1'b1, 4'h5, 12'h300, 16'h8C60, 12'hF60},
            '{1'b1, 4'hF, 12'h300, 16'h8503, 12'hF03}};
        arst_n = 1'b0;
        {hsel, hwrite, instr_valid} = 3'b000;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'h2;
        instr_word = 16'h0000;
        pc_incr = 21'h0;
        flags = 4'h0;
        repeat (8) @(posedge clk);
        `CHK("rst ready", 1'b1, hreadyout)
        `CHK("rst outs", 3'b000, {pc_load, fetch_flush, mem_req.rd})
        `CHK("rst phase", PH_Q1, q_phase)
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // status bits 1:0 follow the running phase, so they are masked
        for (int a = 0; a < 20; a += 4) begin
            ahb(1'b0, 8'(a), 32'h0, rd);
            `CHK("reg reset", 32'h0, (a == 12) ? (rd & 32'hFFFF_FFFC) : rd)
            `CHK("hresp", 1'b0, hresp)
        end
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h10, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        $display("reset and register test done");
        for (int i = 0; i < 14; i++) begin
            issue(br[i].w, br[i].f);
            `CHK("pc_load", br[i].tk, pc_load)
            if (br[i].tk) `CHK("pc_target", tgt(br[i].w), pc_target)
            `CHK("slice_active", i < 12, slice_active)
        end
        ahb(1'b0, REG_STAT, 32'h0, rd);
        `CHK("stat taken", 9'h00F, {rd[15:8], rd[3]})
        $display("branch table test done");
        issue(16'hE67F, 4'h8);
        @(posedge clk);
        instr_word <= 16'hD3FF;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("stale word", 2'b01, {pc_load, fetch_flush})
        issue(16'hD3FF, 4'h0);
        `CHK("after flush", 1'b1, pc_load)
        `CHK("after flush tgt", tgt(16'hD3FF), pc_target)
        $display("flush test done");
        for (int i = 0; i < 7; i++) begin
            ahb(1'b1, REG_CTRL, {31'h0, sr[i].ext}, rd);
            ahb(1'b1, REG_BANK, {28'h0, sr[i].bk}, rd);
            ahb(1'b1, REG_IDX, {20'h0, sr[i].ix}, rd);
            issue(sr[i].w, 4'h0);
            @(posedge clk);
            #1;
            eb = (sr[i].a[7:0] ^ 8'hA5) | (8'h01 << sr[i].w[11:9]);
            `CHK("bit set", eb, i_mem.mem[sr[i].a])
        end
        $display("bit set test done");
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("mid rst outs", 3'b000, {pc_load, fetch_flush, mem_req.wr})
        `CHK("mid rst phase", PH_Q1, q_phase)
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ahb(1'b0, REG_BANK, 32'h0, rd);
        `CHK("mid rst bank", 32'h0, rd)
        $display("mid-run reset test done");
        close_out();
    end
endmodule
bind bbd_exec bbd_exec_sva #(.PCW(PCW)) i_sva (.clk(clk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .pc_incr(pc_incr),
    .flags(flags), .pc_load(pc_load), .pc_target(pc_target),
    .fetch_flush(fetch_flush), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .q_phase(q_phase));
`default_nettype wire
